// ---- common/msd_map.svh ----
// Register offsets, field positions and reset values of the multiply/shift datapath.
// Assumes byte addressing on a 32-bit APB with word-aligned registers.
`ifndef MSD_MAP_SVH
`define MSD_MAP_SVH

`define MSD_OFS_STATUS_WORD_ZERO 8'h00
`define MSD_OFS_STATUS_WORD_ONE  8'h04
`define MSD_OFS_ACCUMULATOR      8'h08
`define MSD_OFS_PRODUCT          8'h0c

`define MSD_POS_SATURATION_ENABLE 11
`define MSD_POS_OVERFLOW_FLAG     12
`define MSD_POS_SHIFT_SEL_LO      0
`define MSD_POS_SHIFT_SEL_HI      1

`define MSD_RST_STATUS_WORD_ZERO 16'h0000
`define MSD_RST_STATUS_WORD_ONE  16'h0000
`define MSD_RST_ACCUMULATOR      32'h0000_0000
`define MSD_RST_PRODUCT          32'h0000_0000

`define MSD_ACC_MOST_POSITIVE 32'h7fff_ffff
`define MSD_ACC_MOST_NEGATIVE 32'h8000_0000

`endif

// ---- common/msd_pkg.sv ----
// Types shared by the multiply/shift datapath modules.
// Assumes the offsets and field positions come from msd_map.svh.
package msd_pkg;

	typedef enum logic [1:0] {
		SHIFT_NONE   = 2'b00,
		SHIFT_LEFT1  = 2'b01,
		SHIFT_LEFT4  = 2'b10,
		SHIFT_RIGHT6 = 2'b11
	} shift_sel_e;

	typedef enum logic [1:0] {
		ACC_LOAD_PRODUCT = 2'b00,
		ACC_ADD_PRODUCT  = 2'b01,
		ACC_SUB_PRODUCT  = 2'b10,
		ACC_ADD_DATA     = 2'b11
	} acc_op_e;

	typedef logic [31:0] word_t;

endpackage : msd_pkg

// ---- common/mul_if.sv ----
// Carrier between the datapath top and its multiplier/product-shifter module.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface mul_if;
	import msd_pkg::*;

	logic        issue;
	logic        signed_mode;
	logic [15:0] operand_a;
	logic [15:0] operand_b;
	shift_sel_e  shift_sel;
	word_t       product;
	word_t       shifted_product;

	modport ctrl (
		output issue,
		output signed_mode,
		output operand_a,
		output operand_b,
		output shift_sel,
		input  product,
		input  shifted_product
	);

	modport unit (
		input  issue,
		input  signed_mode,
		input  operand_a,
		input  operand_b,
		input  shift_sel,
		output product,
		output shifted_product
	);
endinterface : mul_if
`default_nettype wire

// ---- design/msd_datapath.sv ----
// Multiply, accumulate-with-saturation and output-shifter datapath with an APB slave.
// Assumes the processor control logic issues at most one operation of each kind per cycle.
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "msd_map.svh"

// Contract
// (RULE_01) Two 16-bit operands give a full 32-bit product on every issued multiply.
// (RULE_02) Operands are treated as signed or unsigned, chosen per multiply.
// (RULE_03) Product is kept in a 32-bit holding register until the next multiply.
// (RULE_04) Product shifter: no shift, left one, left four, or arithmetic right six.
// (RULE_05) Shift selection comes from bits one and zero of status word one.
// (RULE_06) Selection codes: 00 none, 01 left one, 10 left four, 11 right six.
// (RULE_07) With saturation on, overflow loads most positive or most negative value.
// (RULE_08) Saturation enable is bit eleven of status word zero.
// (RULE_09) Overflow flag, bit twelve of status word zero, sets on accumulator overflow.
// (RULE_10) Store shifts accumulator left 0 to 7, drives upper or lower half out.
// (RULE_11) With saturation off, overflow wraps modulo 2^32 and still sets the flag.
module msd_datapath
	import msd_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	// APB slave.
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Multiply issue.
	input  wire logic        mul_issue_i,
	input  wire logic        mul_signed_i,
	input  wire logic [15:0] mul_operand_a_i,
	input  wire logic [15:0] mul_operand_b_i,
	// Accumulator operation.
	input  wire logic        acc_issue_i,
	input  wire logic [1:0]  acc_op_i,
	input  wire logic [31:0] acc_data_i,
	// Store through the output shifter.
	input  wire logic        store_issue_i,
	input  wire logic [2:0]  store_shift_i,
	input  wire logic        store_high_i,
	output logic [15:0]      store_data_bus_o,
	output logic             store_valid_o,
	// Observed state.
	output logic [31:0]      accumulator_o,
	output logic             overflow_flag_o
);

	typedef struct packed {
		logic [15:0] status_word_zero;
		logic [15:0] status_word_one;
		word_t       accumulator;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic [15:0] store_data;
		logic        store_valid;
	} dp_state_s;

	dp_state_s state_q;
	dp_state_s state_d;

	mul_if mif ();

	mul_shift_unit u_mul_shift_unit (
		.clk_i  (clk_i),
		.rstn_i (rstn_i),
		.mif    (mif.unit)
	);

	logic        saturation_enable;
	logic [32:0] acc_sum;
	logic        acc_overflow;
	word_t       acc_result;
	word_t       store_shifted;
	logic        setup_phase;
	logic        wr_st0;
	logic        wr_st1;
	logic        addr_known;

	// The enable is read from the registered status word, so a write takes effect on the
	// operation after the one issued in its setup cycle.
	assign saturation_enable = state_q.status_word_zero[`MSD_POS_SATURATION_ENABLE]; // RULE_08

	// The product register is the only multiplier stage, so an accumulate issued together
	// with a multiply still works on the previous product.
	assign mif.issue       = mul_issue_i; // RULE_01
	assign mif.signed_mode = mul_signed_i; // RULE_02
	assign mif.operand_a   = mul_operand_a_i;
	assign mif.operand_b   = mul_operand_b_i;
	assign mif.shift_sel   = shift_sel_e'(state_q.status_word_one[`MSD_POS_SHIFT_SEL_HI:
		`MSD_POS_SHIFT_SEL_LO]); // RULE_05

	// Sign-extended 33-bit sum: overflow shows as bits 32 and 31 differing.
	always_comb
	begin
		unique case (acc_op_e'(acc_op_i))
			ACC_LOAD_PRODUCT: acc_sum = {mif.shifted_product[31], mif.shifted_product};
			ACC_ADD_PRODUCT:  acc_sum = {state_q.accumulator[31], state_q.accumulator}
				+ {mif.shifted_product[31], mif.shifted_product};
			ACC_SUB_PRODUCT:  acc_sum = {state_q.accumulator[31], state_q.accumulator}
				- {mif.shifted_product[31], mif.shifted_product};
			ACC_ADD_DATA:     acc_sum = {state_q.accumulator[31], state_q.accumulator}
				+ {acc_data_i[31], acc_data_i};
		endcase
	end

	assign acc_overflow = acc_sum[32] ^ acc_sum[31]; // RULE_09

	always_comb
	begin
		if (acc_overflow && saturation_enable)
		begin
			// The true sign of the sum sits in bit 32, not in the wrapped bit 31.
			acc_result = acc_sum[32] ? `MSD_ACC_MOST_NEGATIVE : `MSD_ACC_MOST_POSITIVE; // RULE_07
		end
		else
		begin
			acc_result = acc_sum[31:0]; // RULE_11
		end
	end

	// Bits shifted past bit 31 are lost; software picks the shift that keeps the half it stores.
	assign store_shifted = state_q.accumulator << store_shift_i; // RULE_10

	assign setup_phase = psel_i && !penable_i;
	assign wr_st0      = setup_phase && pwrite_i && (paddr_i == `MSD_OFS_STATUS_WORD_ZERO);
	assign wr_st1      = setup_phase && pwrite_i && (paddr_i == `MSD_OFS_STATUS_WORD_ONE);
	assign addr_known  = (paddr_i == `MSD_OFS_STATUS_WORD_ZERO)
		|| (paddr_i == `MSD_OFS_STATUS_WORD_ONE)
		|| (paddr_i == `MSD_OFS_ACCUMULATOR)
		|| (paddr_i == `MSD_OFS_PRODUCT);

	always_comb
	begin
		state_d             = state_q;
		state_d.pready      = 1'b0;
		state_d.pslverr     = 1'b0;
		state_d.store_valid = 1'b0;

		// Writes are committed in the setup cycle; the access phase then completes at once.
		if (setup_phase)
		begin
			state_d.pready  = 1'b1;
			// Unmapped offsets answer with an error and read as zero; writes there change nothing.
			state_d.pslverr = !addr_known;
			state_d.prdata  = 32'h0000_0000;
			if (!pwrite_i)
			begin
				unique case (paddr_i)
					`MSD_OFS_STATUS_WORD_ZERO: state_d.prdata = {16'h0000, state_q.status_word_zero};
					`MSD_OFS_STATUS_WORD_ONE:  state_d.prdata = {16'h0000, state_q.status_word_one};
					`MSD_OFS_ACCUMULATOR:      state_d.prdata = state_q.accumulator;
					`MSD_OFS_PRODUCT:          state_d.prdata = mif.product;
					default:                   state_d.prdata = 32'h0000_0000;
				endcase
			end
		end

		if (wr_st0)
		begin
			state_d.status_word_zero = pwdata_i[15:0];
		end
		if (wr_st1)
		begin
			state_d.status_word_one = pwdata_i[15:0];
		end

		if (acc_issue_i)
		begin
			state_d.accumulator = acc_result;
			// A hardware set beats a software clear written in the same cycle.
			if (acc_overflow)
			begin
				state_d.status_word_zero[`MSD_POS_OVERFLOW_FLAG] = 1'b1; // RULE_09 RULE_11
			end
		end

		if (store_issue_i)
		begin
			state_d.store_valid = 1'b1;
			state_d.store_data  = store_high_i ? store_shifted[31:16] : store_shifted[15:0]; // RULE_10
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			state_q <= '{
				status_word_zero: `MSD_RST_STATUS_WORD_ZERO,
				status_word_one:  `MSD_RST_STATUS_WORD_ONE,
				accumulator:      `MSD_RST_ACCUMULATOR,
				prdata:           32'h0000_0000,
				pready:           1'b0,
				pslverr:          1'b0,
				store_data:       16'h0000,
				store_valid:      1'b0
			};
		end
		else
		begin
			state_q <= state_d;
		end
	end

	// Every output is a flop of the state struct, so no combinational path reaches a pin.
	assign prdata_o         = state_q.prdata;
	assign pready_o         = state_q.pready;
	assign pslverr_o        = state_q.pslverr;
	assign store_data_bus_o = state_q.store_data;
	assign store_valid_o    = state_q.store_valid;
	assign accumulator_o    = state_q.accumulator;
	assign overflow_flag_o  = state_q.status_word_zero[`MSD_POS_OVERFLOW_FLAG];

endmodule : msd_datapath
`default_nettype wire

// ---- design/mul_shift_unit.sv ----
// Multiplier with its product holding register and the product shifter.
// Assumes the issuing side holds operands valid in the cycle issue is high.
`timescale 1ns/10ps
`default_nettype none
`include "msd_map.svh"

module mul_shift_unit
	import msd_pkg::*;
(
	// Clock and reset.
	input  wire logic clk_i,
	input  wire logic rstn_i,
	// Control side.
	mul_if.unit       mif
);

	typedef struct packed {
		word_t product_holding_reg;
	} unit_state_s;

	unit_state_s state_q;
	unit_state_s state_d;
	logic signed [16:0] ext_a;
	logic signed [16:0] ext_b;
	logic signed [33:0] full_product;

	// One extra bit per operand lets a single signed multiplier serve both modes.
	assign ext_a        = $signed({mif.signed_mode & mif.operand_a[15], mif.operand_a}); // RULE_02
	assign ext_b        = $signed({mif.signed_mode & mif.operand_b[15], mif.operand_b}); // RULE_02
	assign full_product = ext_a * ext_b; // RULE_01

	always_comb
	begin
		state_d = state_q;
		if (mif.issue)
		begin
			state_d.product_holding_reg = full_product[31:0]; // RULE_03
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			state_q <= '{product_holding_reg: `MSD_RST_PRODUCT};
		end
		else
		begin
			state_q <= state_d;
		end
	end

	assign mif.product = state_q.product_holding_reg;

	always_comb
	begin
		unique case (mif.shift_sel) // RULE_04 RULE_06
			SHIFT_NONE:   mif.shifted_product = state_q.product_holding_reg;
			SHIFT_LEFT1:  mif.shifted_product = {state_q.product_holding_reg[30:0], 1'b0};
			SHIFT_LEFT4:  mif.shifted_product = {state_q.product_holding_reg[27:0], 4'h0};
			SHIFT_RIGHT6: mif.shifted_product = {{6{state_q.product_holding_reg[31]}},
				state_q.product_holding_reg[31:6]};
		endcase
	end

endmodule : mul_shift_unit
`default_nettype wire

// ---- verification/msd_ctl_model.sv ----
// Control-side model that issues multiply, accumulate and store operations.
// Assumes one task at a time, called just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module msd_ctl_model (
	input  wire logic   clk_i,
	output logic [73:0] op_o
);
	initial
		op_o = '0;
	task automatic put(input logic [73:0] v);
		op_o <= v;
		@(posedge clk_i);
		op_o <= '0;
		@(posedge clk_i);
	endtask : put
	task automatic mul(input logic s, input logic [15:0] a, input logic [15:0] b);
		put({1'b1, s, a, b, 40'h0});
	endtask : mul
	task automatic acc(input logic [1:0] o, input logic [31:0] d);
		put({34'h0, 1'b1, o, d, 5'h0});
	endtask : acc
	task automatic store(input logic [2:0] k, input logic h);
		put({69'h0, 1'b1, k, h});
	endtask : store
endmodule : msd_ctl_model
`default_nettype wire

// ---- verification/msd_datapath_props.sv ----
// Checker bound to msd_datapath: store, accumulate, flag and APB answer timing.
// Assumes the saturation enable bit of status word zero changes only through APB write setup cycles.
`timescale 1ns/10ps
`default_nettype none
module msd_datapath_props (
	input wire logic        clk_i,
	input wire logic        rstn_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic        pready_o,
	input wire logic        acc_issue_i,
	input wire logic [1:0]  acc_op_i,
	input wire logic [31:0] acc_data_i,
	input wire logic        store_issue_i,
	input wire logic [2:0]  store_shift_i,
	input wire logic        store_high_i,
	input wire logic [15:0] store_data_bus_o,
	input wire logic        store_valid_o,
	input wire logic [31:0] accumulator_o,
	input wire logic        overflow_flag_o
);
	logic        sat_q, setup, wr0, ovf;
	logic [32:0] sum;
	logic [31:0] add_exp, st_w;
	logic [15:0] st_exp;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);
	assign setup = psel_i && !penable_i;
	assign wr0 = setup && pwrite_i && paddr_i == 8'h00;
	assign sum = {accumulator_o[31], accumulator_o} + {acc_data_i[31], acc_data_i};
	assign ovf = sum[32] ^ sum[31];
	assign add_exp = (sat_q && ovf) ? (sum[32] ? 32'h8000_0000 : 32'h7fff_ffff) : sum[31:0];
	assign st_w = accumulator_o << store_shift_i;
	assign st_exp = store_high_i ? st_w[31:16] : st_w[15:0];
	// The enable is mirrored here because the checker sees no internal state.
	always_ff @(posedge clk_i or negedge rstn_i)
		if (!rstn_i)
			sat_q <= 1'b0;
		else if (wr0)
			sat_q <= pwdata_i[11];
	sequence s_store;
		store_issue_i ##1 !store_issue_i;
	endsequence
	AST_STORE_PULSE: assert property (s_store |-> store_valid_o ##1 !store_valid_o)
		else $error("store valid is not one pulse");
	AST_STORE_DATA: assert property (store_issue_i |=> store_data_bus_o == $past(st_exp))
		else $error("store data wrong");
	AST_ADD_DATA: assert property (acc_issue_i && acc_op_i == 2'b11 |=>
		accumulator_o == $past(add_exp)) else $error("accumulated sum wrong");
	AST_OVF_SET: assert property (acc_issue_i && acc_op_i == 2'b11 && ovf |=> overflow_flag_o)
		else $error("overflow flag not set");
	AST_FLAG_KEEP: assert property (overflow_flag_o && !wr0 |=> overflow_flag_o)
		else $error("overflow flag dropped");
	AST_FLAG_CLEAR: assert property (wr0 && !pwdata_i[12] && !acc_issue_i |=> !overflow_flag_o)
		else $error("overflow flag not cleared");
	AST_ACC_HOLD: assert property (!acc_issue_i |=> $stable(accumulator_o))
		else $error("accumulator changed unasked");
	AST_ACK: assert property (setup |=> pready_o ##1 !pready_o)
		else $error("register answer late");
endmodule : msd_datapath_props
bind msd_datapath msd_datapath_props u_props (
	.clk_i            (clk_i),
	.rstn_i           (rstn_i),
	.psel_i           (psel_i),
	.penable_i        (penable_i),
	.pwrite_i         (pwrite_i),
	.paddr_i          (paddr_i),
	.pwdata_i         (pwdata_i),
	.pready_o         (pready_o),
	.acc_issue_i      (acc_issue_i),
	.acc_op_i         (acc_op_i),
	.acc_data_i       (acc_data_i),
	.store_issue_i    (store_issue_i),
	.store_shift_i    (store_shift_i),
	.store_high_i     (store_high_i),
	.store_data_bus_o (store_data_bus_o),
	.store_valid_o    (store_valid_o),
	.accumulator_o    (accumulator_o),
	.overflow_flag_o  (overflow_flag_o)
);
`default_nettype wire

// ---- verification/msd_datapath_tb_top.sv ----
// Self-checking bench of msd_datapath over APB and the operation ports.
// Assumes msd_ctl_model drives the operation ports.
`timescale 1ns/10ps
`default_nettype none
module msd_datapath_tb_top
	import msd_pkg::*;
;
	logic        clk_i, rstn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
	logic        mul_issue_i, mul_signed_i, acc_issue_i, store_issue_i, store_high_i;
	logic        store_valid_o, overflow_flag_o;
	logic [7:0]  paddr_i;
	logic [1:0]  acc_op_i;
	logic [2:0]  store_shift_i;
	logic [15:0] mul_operand_a_i, mul_operand_b_i, store_data_bus_o;
	logic [73:0] ctl;
	word_t       pwdata_i, prdata_o, acc_data_i, accumulator_o, rd;
	int          errors = 0, n_tests = 0, cyc = 0;
	assign {mul_issue_i, mul_signed_i, mul_operand_a_i, mul_operand_b_i, acc_issue_i,
		acc_op_i, acc_data_i, store_issue_i, store_shift_i, store_high_i} = ctl;
	msd_datapath u_dut (
		.clk_i            (clk_i),
		.rstn_i           (rstn_i),
		.psel_i           (psel_i),
		.penable_i        (penable_i),
		.pwrite_i         (pwrite_i),
		.paddr_i          (paddr_i),
		.pwdata_i         (pwdata_i),
		.prdata_o         (prdata_o),
		.pready_o         (pready_o),
		.pslverr_o        (pslverr_o),
		.mul_issue_i      (mul_issue_i),
		.mul_signed_i     (mul_signed_i),
		.mul_operand_a_i  (mul_operand_a_i),
		.mul_operand_b_i  (mul_operand_b_i),
		.acc_issue_i      (acc_issue_i),
		.acc_op_i         (acc_op_i),
		.acc_data_i       (acc_data_i),
		.store_issue_i    (store_issue_i),
		.store_shift_i    (store_shift_i),
		.store_high_i     (store_high_i),
		.store_data_bus_o (store_data_bus_o),
		.store_valid_o    (store_valid_o),
		.accumulator_o    (accumulator_o),
		.overflow_flag_o  (overflow_flag_o)
	);
	msd_ctl_model u_ctl (.clk_i(clk_i), .op_o(ctl));
	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			errors++;
			complete_run();
		end
	end
	task automatic chk(input string nm, input word_t exp, input word_t got);
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input word_t d);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		// Only the bench's cycle ceiling ends a wait for the answer.
		do
			@(posedge clk_i);
		while (pready_o !== 1'b1);
		rd = {prdata_o[31:1], prdata_o[0]};
		chk("error", {31'h0, a[7:4] != 4'h0}, {31'h0, pslverr_o});
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clk_i);
	endtask : apb
	function automatic word_t shp(input word_t p, input int m);
		case (m)
			0: return p;
			1: return p << 1;
			2: return p << 4;
			default: return word_t'($signed(p) >>> 6);
		endcase
	endfunction : shp
	task automatic clr();
		u_ctl.mul(1'b0, '0, '0);
		u_ctl.acc(ACC_LOAD_PRODUCT, '0);
	endtask : clr
	task automatic t_regs();
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b0, 8'(i * 4), '0);
			chk("reset word", '0, rd);
		end
		apb(1'b1, 8'h20, 32'h0000_ffff);
		apb(1'b1, 8'h08, 32'h1234_5678);
		apb(1'b0, 8'h08, '0);
		chk("read only", '0, rd);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_mul();
		word_t p;
		for (int m = 0; m < 4; m++)
			for (int s = 0; s < 2; s++)
			begin
				apb(1'b1, 8'h04, word_t'(m));
				u_ctl.mul(s[0], 16'hfffd, 16'h9000);
				p = s ? 32'h0001_5000 : 32'h8ffe_5000;
				u_ctl.acc(ACC_LOAD_PRODUCT, '0);
				chk("load", shp(p, m), accumulator_o);
				u_ctl.acc(ACC_ADD_PRODUCT, '0);
				chk("add", shp(p, m) << 1, accumulator_o);
				u_ctl.acc(ACC_SUB_PRODUCT, '0);
				chk("sub", shp(p, m), accumulator_o);
				apb(1'b0, 8'h0c, '0);
				chk("product", p, rd);
			end
		$display("t_mul done");
	endtask : t_mul
	task automatic t_sat();
		for (int e = 0; e < 2; e++)
		begin
			apb(1'b1, 8'h00, e ? 32'h0000_0800 : '0);
			clr();
			u_ctl.acc(ACC_ADD_DATA, 32'h7fff_ffff);
			u_ctl.acc(ACC_ADD_DATA, 32'h0000_0002);
			chk("pos", e ? 32'h7fff_ffff : 32'h8000_0001, accumulator_o);
			apb(1'b0, 8'h00, '0);
			chk("status", e ? 32'h0000_1800 : 32'h0000_1000, rd);
			clr();
			u_ctl.acc(ACC_ADD_DATA, 32'h8000_0000);
			u_ctl.acc(ACC_ADD_DATA, 32'hffff_fffe);
			chk("neg", e ? 32'h8000_0000 : 32'h7fff_fffe, accumulator_o);
			apb(1'b1, 8'h00, '0);
			apb(1'b0, 8'h00, '0);
			chk("cleared", '0, rd);
		end
		$display("t_sat done");
	endtask : t_sat
	task automatic t_store();
		word_t v;
		clr();
		u_ctl.acc(ACC_ADD_DATA, 32'h9abc_def1);
		for (int k = 0; k < 8; k++)
			for (int h = 0; h < 2; h++)
			begin
				u_ctl.store(k[2:0], h[0]);
				v = 32'h9abc_def1 << k;
				chk("store", h ? v[31:16] : v[15:0], {16'h0, store_data_bus_o});
			end
		$display("t_store done");
	endtask : t_store
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run
	initial
	begin
		{rstn_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
		repeat (20) @(posedge clk_i);
		rstn_i <= 1'b1;
		@(posedge clk_i);
		t_regs();
		t_mul();
		t_sat();
		t_store();
		complete_run();
	end
endmodule : msd_datapath_tb_top
`default_nettype wire
